// ==== core_model.sv ====
`timescale 1ns/10ps
// behavioural core: issues one register request at a time
module core_model
(
    // clock
    input wire logic ref_clk,
    // register port
    output sysctl_pkg::reg_req_t req,
    input wire sysctl_pkg::reg_rsp_t rsp
);
    import sysctl_pkg::*;

    initial req = '0;

    // callers use aligned words except on the narrow-capable registers,
    // unless a refusal is the point of the access
    task automatic access(input logic wr, input logic [31:0] a, input acc_size_t sz,
        input logic [31:0] d, output reg_rsp_t r);
        int n;
        @(posedge ref_clk);
        req <= '{valid: 1'b1, write: wr, addr: a, size: sz, wdata: d};
        @(posedge ref_clk);
        req.valid <= 1'b0;
        req.wdata <= ~d; // released data must not keep its last value
        r = '0;
        // answer is due one cycle after the take; a few spare cycles catch a late reply
        for (n = 0; n < 4 && r.ready !== 1'b1; n++)
        begin
            #1;
            r = rsp;
            if (r.ready !== 1'b1)
                @(posedge ref_clk);
        end
    endtask
endmodule

// ==== sysctl_lane_merge.sv ====
`timescale 1ns/10ps
// merges written byte lanes into a stored word
module sysctl_lane_merge
(
    // stored word and new data
    input wire logic [31:0] old_word,
    input wire logic [31:0] new_word,
    input wire logic [3:0] lanes,
    // merged result
    output logic [31:0] merged
);
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : lane
            assign merged[8*g +: 8] = lanes[g] ? new_word[8*g +: 8] : old_word[8*g +: 8];
        end
    endgenerate
endmodule

// ==== sysctl_map.svh ====
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH

// word addresses of the block registers
`define ADDR_AUX_CTRL 32'hE000E008
`define ADDR_CPU_ID 32'hE000ED00
`define ADDR_ICSR 32'hE000ED04
`define ADDR_VTOR 32'hE000ED08
`define ADDR_AIRCR 32'hE000ED0C
`define ADDR_SCR 32'hE000ED10
`define ADDR_CCR 32'hE000ED14
`define ADDR_SHPR1 32'hE000ED18
`define ADDR_SHPR2 32'hE000ED1C
`define ADDR_SHPR3 32'hE000ED20
`define ADDR_SHCSR 32'hE000ED24
`define ADDR_CFSR 32'hE000ED28
`define ADDR_HFSR 32'hE000ED2C
`define ADDR_MMFAR 32'hE000ED34
`define ADDR_BFAR 32'hE000ED38
`define ADDR_AFSR 32'hE000ED3C
`define ADDR_TRIGGER 32'hE000EF00

// reset values
`define RST_AIRCR 32'hFA050000
`define RST_CCR 32'h00000200
`define RST_ZERO 32'h00000000

// key that unlocks the interrupt and reset control word, and its writable low bits
`define AIRCR_KEY 16'h05FA
`define AIRCR_WR_MASK 32'h00000707

// auxiliary control field positions and writable mask
`define AUX_NO_MCYC 0
`define AUX_NO_WBUF 1
`define AUX_NO_FOLD 2
`define AUX_NO_FLOAT_CONTEXT_ACTIVE 8
`define AUX_NO_OOFP 9
`define AUX_MASK 32'h00000307

// fault status valid flag positions
`define CFSR_MM_VALID 7
`define CFSR_BF_VALID 15

// identification word constant and trigger number limit
`define ID_CONST_VAL 4'hF
`define TRIG_MAX 9'h0EF

`endif

// ==== sysctl_pkg.sv ====
package sysctl_pkg;
    // access size as carried on the register port
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_BAD} acc_size_t;

    // one register request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        acc_size_t size;
        logic [31:0] wdata;
    } reg_req_t;

    // answer to a request
    typedef struct packed {
        logic ready;
        logic error;
        logic [31:0] rdata;
    } reg_rsp_t;

    // auxiliary control outputs
    typedef struct packed {
        logic no_out_of_order_float;
        logic no_float_context_autoupdate;
        logic no_conditional_overlap;
        logic no_default_write_buffer;
        logic no_multicycle_interrupt;
    } aux_ctrl_t;
endpackage

// ==== sysctl_regs.sv ====
`timescale 1ns/10ps
`include "sysctl_map.svh"
// Contract
// - trigger number field picks pending external interrupt, legal values 0 to 239
// - fault status and handler priorities take byte, halfword and word accesses
// - unaligned accesses are not serviced as register operations
// - fault addresses are meaningful only while their valid flag reads one
// - fault status word splits into memory byte, bus byte, usage halfword
// - interrupt and reset control reads key status after reset
// - configuration control resets with bit 9 set, other bits zero
// - fault address registers have no defined reset value
// - aux bit 9 stops out-of-order float completion
// - aux bit 8 stops float context active flag autoupdate
// - aux bit 2 stops conditional block overlap
// - aux bit 1 bypasses default write buffer
// - aux bit 0 forbids interrupting multiple load and store
// - identification word packs implementer, variant, constant, part, revision fields
// - identification constant field always reads fixed value
// - variant field reports major revision
// - revision field reports patch number
// - trigger register is write-only and reads zero
module sysctl_regs #(
    parameter logic [7:0] IMPLEMENTER = 8'h5A, // arbitrary value
    parameter logic [3:0] VARIANT = 4'h0,
    parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
    parameter logic [3:0] REVISION = 4'h0
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire sysctl_pkg::reg_req_t req,
    output sysctl_pkg::reg_rsp_t rsp,
    // fault capture from the core
    input wire logic memfault_capture,
    input wire logic [31:0] memfault_addr_in,
    input wire logic busfault_capture,
    input wire logic [31:0] busfault_addr_in,
    // controls to the core
    output sysctl_pkg::aux_ctrl_t aux_ctrl,
    output logic trigger_valid,
    output logic [8:0] trigger_irq_number
);
    import sysctl_pkg::*;

    logic [31:0] aux_q;
    logic [31:0] icsr_q;
    logic [31:0] vtor_q;
    logic [31:0] aircr_q;
    logic [31:0] scr_q;
    logic [31:0] ccr_q;
    logic [31:0] shpr_q [3];
    logic [31:0] shcsr_q;
    logic [31:0] cfsr_q;
    logic [31:0] hfsr_q;
    logic [31:0] mmfar_q;
    logic [31:0] bfar_q;
    logic [31:0] afsr_q;
    logic [31:0] word_addr;
    logic [3:0] lanes;
    logic aligned;
    logic narrow_ok;
    logic hit;
    logic ok;
    logic wr;
    logic [31:0] wdata_lane;
    logic [31:0] cfsr_merged;
    logic [31:0] shpr_merged [3];
    logic [31:0] rd_d;
    logic [31:0] cpu_id;

    // byte lanes touched by an access, from size and low address bits
    function automatic logic [3:0] lane_mask(input acc_size_t sz, input logic [1:0] a);
        unique case (sz)
            SZ_BYTE: lane_mask = 4'h1 << a;
            SZ_HALF: lane_mask = a[1] ? 4'hC : 4'h3;
            SZ_WORD: lane_mask = 4'hF;
            default: lane_mask = 4'h0;
        endcase
    endfunction

    // registers that accept narrow accesses
    function automatic logic narrow_reg(input logic [31:0] wa);
        narrow_reg = (wa == `ADDR_CFSR) || (wa == `ADDR_SHPR1) ||
                     (wa == `ADDR_SHPR2) || (wa == `ADDR_SHPR3);
    endfunction

    // decode and size check
    assign word_addr = {req.addr[31:2], 2'b00};
    assign lanes = lane_mask(req.size, req.addr[1:0]);
    assign aligned = (req.size == SZ_BYTE) || (req.size == SZ_HALF && !req.addr[0]) ||
                     (req.size == SZ_WORD && req.addr[1:0] == 2'b00);
    assign narrow_ok = (req.size == SZ_WORD) || narrow_reg(word_addr);
    assign ok = req.valid && aligned && narrow_ok && hit;
    assign wr = ok && req.write;
    // lane replicate so narrow data lands on its own lanes
    assign wdata_lane = (req.size == SZ_BYTE) ? {4{req.wdata[7:0]}} :
                        (req.size == SZ_HALF) ? {2{req.wdata[15:0]}} : req.wdata;

    // fault status uses byte lanes: memory, bus, then usage halfword
    sysctl_lane_merge u_cfsr_merge (
        .old_word(cfsr_q),
        .new_word(~wdata_lane & cfsr_q),
        .lanes(lanes),
        .merged(cfsr_merged)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : shpr_lane
            sysctl_lane_merge u_merge (
                .old_word(shpr_q[gi]),
                .new_word(wdata_lane),
                .lanes(lanes),
                .merged(shpr_merged[gi])
            );
        end
    endgenerate

    // identification word is fixed wiring
    assign cpu_id = {IMPLEMENTER, VARIANT, `ID_CONST_VAL,
                     PART_NUMBER, REVISION};

    // read mux and address hit
    always_comb
    begin
        rd_d = 32'h00000000;
        hit = 1'b1;
        unique case (word_addr)
            `ADDR_AUX_CTRL: rd_d = aux_q & `AUX_MASK;
            `ADDR_CPU_ID: rd_d = cpu_id;
            `ADDR_ICSR: rd_d = icsr_q;
            `ADDR_VTOR: rd_d = vtor_q;
            `ADDR_AIRCR: rd_d = aircr_q;
            `ADDR_SCR: rd_d = scr_q;
            `ADDR_CCR: rd_d = ccr_q;
            `ADDR_SHPR1: rd_d = shpr_q[0];
            `ADDR_SHPR2: rd_d = shpr_q[1];
            `ADDR_SHPR3: rd_d = shpr_q[2];
            `ADDR_SHCSR: rd_d = shcsr_q;
            `ADDR_CFSR: rd_d = cfsr_q;
            `ADDR_HFSR: rd_d = hfsr_q;
            `ADDR_MMFAR: rd_d = mmfar_q;
            `ADDR_BFAR: rd_d = bfar_q;
            `ADDR_AFSR: rd_d = afsr_q;
            `ADDR_TRIGGER: rd_d = 32'h00000000;
            default: hit = 1'b0;
        endcase
    end

    // response: one cycle after the request, error on refused access
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.ready <= req.valid;
            rsp.error <= req.valid && !ok;
            rsp.rdata <= (ok && !req.write) ? rd_d : 32'h00000000;
        end
    end

    // auxiliary control, only implemented bits stored
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            aux_q <= `RST_ZERO;
        else if (wr && word_addr == `ADDR_AUX_CTRL)
            aux_q <= req.wdata & `AUX_MASK;
    end

    // registered controls to the core
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            aux_ctrl <= '0;
        else
        begin
            aux_ctrl.no_out_of_order_float <= aux_q[`AUX_NO_OOFP];
            aux_ctrl.no_float_context_autoupdate <= aux_q[`AUX_NO_FLOAT_CONTEXT_ACTIVE];
            aux_ctrl.no_conditional_overlap <= aux_q[`AUX_NO_FOLD];
            aux_ctrl.no_default_write_buffer <= aux_q[`AUX_NO_WBUF];
            aux_ctrl.no_multicycle_interrupt <= aux_q[`AUX_NO_MCYC];
        end
    end

    // word-only registers; key register only changes on the right key, hard fault status clears written ones
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            icsr_q <= `RST_ZERO;
            vtor_q <= `RST_ZERO;
            aircr_q <= `RST_AIRCR;
            scr_q <= `RST_ZERO;
            ccr_q <= `RST_CCR;
            shcsr_q <= `RST_ZERO;
            hfsr_q <= `RST_ZERO;
            afsr_q <= `RST_ZERO;
        end
        else if (wr)
        begin
            if (word_addr == `ADDR_ICSR)
                icsr_q <= req.wdata;
            if (word_addr == `ADDR_VTOR)
                vtor_q <= {req.wdata[31:7], 7'h00};
            // key field always reads back the status value, masked low bits writable
            if (word_addr == `ADDR_AIRCR && req.wdata[31:16] == `AIRCR_KEY)
                aircr_q <= `RST_AIRCR | (req.wdata & `AIRCR_WR_MASK);
            if (word_addr == `ADDR_SCR)
                scr_q <= req.wdata;
            if (word_addr == `ADDR_CCR)
                ccr_q <= req.wdata;
            if (word_addr == `ADDR_SHCSR)
                shcsr_q <= req.wdata;
            if (word_addr == `ADDR_HFSR)
                hfsr_q <= hfsr_q & ~req.wdata;
            if (word_addr == `ADDR_AFSR)
                afsr_q <= req.wdata;
        end
    end

    // handler priorities accept narrow writes on their own lanes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            shpr_q[0] <= `RST_ZERO;
            shpr_q[1] <= `RST_ZERO;
            shpr_q[2] <= `RST_ZERO;
        end
        else if (wr)
        begin
            if (word_addr == `ADDR_SHPR1)
                shpr_q[0] <= shpr_merged[0];
            if (word_addr == `ADDR_SHPR2)
                shpr_q[1] <= shpr_merged[1];
            if (word_addr == `ADDR_SHPR3)
                shpr_q[2] <= shpr_merged[2];
        end
    end

    // fault status: write one clears, a capture sets and wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            cfsr_q <= `RST_ZERO;
        else
        begin
            cfsr_q <= (wr && word_addr == `ADDR_CFSR) ? cfsr_merged : cfsr_q;
            if (memfault_capture)
                cfsr_q[`CFSR_MM_VALID] <= 1'b1;
            if (busfault_capture)
                cfsr_q[`CFSR_BF_VALID] <= 1'b1;
        end
    end

    // fault addresses: no reset, loaded on capture or write
    always_ff @(posedge ref_clk)
    begin
        if (memfault_capture)
            mmfar_q <= memfault_addr_in;
        else if (wr && word_addr == `ADDR_MMFAR)
            mmfar_q <= req.wdata;
        if (busfault_capture)
            bfar_q <= busfault_addr_in;
        else if (wr && word_addr == `ADDR_BFAR)
            bfar_q <= req.wdata;
    end

    // software trigger: a one-cycle pulse, withheld for out-of-range numbers though the number field still loads
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            trigger_valid <= 1'b0;
            trigger_irq_number <= 9'h000;
        end
        else
        begin
            trigger_valid <= wr && word_addr == `ADDR_TRIGGER &&
                             req.wdata[8:0] <= `TRIG_MAX;
            if (wr && word_addr == `ADDR_TRIGGER)
                trigger_irq_number <= req.wdata[8:0];
        end
    end

    // checks on the register port and stored state
    a_reset_aircr: assert property (@(posedge ref_clk)
        !rst_b |=> aircr_q == `RST_AIRCR)
        else $error("key status wrong after reset");
    a_reset_ccr: assert property (@(posedge ref_clk)
        !rst_b |=> ccr_q == `RST_CCR)
        else $error("ccr reset wrong");
    a_unaligned_refused: assert property (@(posedge ref_clk) disable iff (!rst_b)
        req.valid && req.size == SZ_WORD && req.addr[1:0] != 2'b00 |=> rsp.error)
        else $error("unaligned word not refused");
    a_narrow_refused: assert property (@(posedge ref_clk) disable iff (!rst_b)
        req.valid && req.size == SZ_BYTE && word_addr == `ADDR_CCR |=> rsp.error)
        else $error("byte to word-only register taken");
    a_narrow_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
        req.valid && req.size == SZ_BYTE && word_addr == `ADDR_SHPR2 |=> !rsp.error)
        else $error("byte to priority refused");
    // the write path itself must drop reserved bits, not only the read mux
    a_aux_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr && word_addr == `ADDR_AUX_CTRL |=> aux_q == ($past(req.wdata) & `AUX_MASK))
        else $error("reserved aux bit stored");
    a_aux_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 aux_ctrl.no_conditional_overlap == $past(aux_q[`AUX_NO_FOLD]))
        else $error("overlap control lags");
    // looked at through the read port so a broken read mux is caught too
    a_id_const: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ok && !req.write && word_addr == `ADDR_CPU_ID |=> rsp.rdata[19:16] == `ID_CONST_VAL)
        else $error("id constant wrong");
    a_trigger_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
        trigger_valid |-> trigger_irq_number <= `TRIG_MAX)
        else $error("trigger out of range");
    a_trigger_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr && word_addr == `ADDR_TRIGGER && req.wdata[8:0] <= `TRIG_MAX |=> trigger_valid)
        else $error("legal trigger number dropped");
    a_trigger_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ok && !req.write && word_addr == `ADDR_TRIGGER |=> rsp.rdata == 32'h0)
        else $error("trigger register read nonzero");

    // capture steps: the pulse, then flag and address together on the next edge
    sequence s_mm_capture;
        memfault_capture;
    endsequence
    sequence s_mm_loaded;
        cfsr_q[`CFSR_MM_VALID] && mmfar_q == $past(memfault_addr_in);
    endsequence
    sequence s_bf_capture;
        busfault_capture;
    endsequence
    sequence s_bf_loaded;
        cfsr_q[`CFSR_BF_VALID] && bfar_q == $past(busfault_addr_in);
    endsequence
    a_mm_valid: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_mm_capture |=> s_mm_loaded)
        else $error("memory fault capture lost");
    a_bf_valid: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_bf_capture |=> s_bf_loaded)
        else $error("bus fault capture lost");
    // a narrow clear of one subregister must leave the bus byte alone
    a_cfsr_lanes: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr && word_addr == `ADDR_CFSR && !lanes[1] && !busfault_capture |=>
        cfsr_q[15:8] == $past(cfsr_q[15:8]))
        else $error("fault status write crossed a byte lane");
endmodule

// ==== test_system_control_block_regs.sv ====
`timescale 1ns/10ps
`include "sysctl_map.svh"
module test_system_control_block_regs;
    import sysctl_pkg::*;
    localparam logic [7:0] IMPL = 8'h3C; // arbitrary value
    localparam logic [11:0] PART = 12'h2B7; // arbitrary value
    localparam logic [3:0] VARI = 4'h2;
    localparam logic [3:0] REV = 4'h6;
    logic ref_clk;
    logic rst_b;
    logic mf_cap;
    logic bf_cap;
    logic trig_v;
    logic [31:0] mf_addr;
    logic [31:0] bf_addr;
    logic [8:0] trig_n;
    reg_req_t req;
    reg_rsp_t rsp;
    reg_rsp_t r;
    aux_ctrl_t aux;
    int errors;
    int tests_run;

    sysctl_regs #(.IMPLEMENTER(IMPL), .VARIANT(VARI), .PART_NUMBER(PART), .REVISION(REV)) uut
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .req(req),
        .rsp(rsp),
        .memfault_capture(mf_cap),
        .memfault_addr_in(mf_addr),
        .busfault_capture(bf_cap),
        .busfault_addr_in(bf_addr),
        .aux_ctrl(aux),
        .trigger_valid(trig_v),
        .trigger_irq_number(trig_n)
    );

    core_model core
    (
        .ref_clk(ref_clk),
        .req(req),
        .rsp(rsp)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [31:0] a, input acc_size_t s,
        input logic [31:0] d);
        core.access(w, a, s, d, r);
        check({31'h0, r.ready}, 32'h1);
    endtask

    // reset values of every stored register except the fault addresses, and of the aux control outputs
    task automatic t_reset;
        int i;
        logic [31:0] adr [13] = '{`ADDR_AUX_CTRL, `ADDR_ICSR, `ADDR_VTOR, `ADDR_AIRCR,
            `ADDR_SCR, `ADDR_CCR, `ADDR_SHPR1, `ADDR_SHPR2, `ADDR_SHPR3, `ADDR_SHCSR,
            `ADDR_CFSR, `ADDR_HFSR, `ADDR_AFSR};
        check({27'h0, aux}, 32'h0);
        for (i = 0; i < 13; i++)
        begin
            acc(1'b0, adr[i], SZ_WORD, 32'h0);
            check(r.rdata, i == 3 ? 32'hFA050000 : i == 5 ? 32'h00000200 : 32'h0);
        end
        // keyed write lands, a write without the key is ignored, key status still reads back
        acc(1'b1, `ADDR_AIRCR, SZ_WORD, 32'h05FA0300);
        acc(1'b1, `ADDR_AIRCR, SZ_WORD, 32'h00000700);
        acc(1'b0, `ADDR_AIRCR, SZ_WORD, 32'h0);
        check(r.rdata, 32'hFA050300);
        acc(1'b0, `ADDR_CPU_ID, SZ_WORD, 32'h0);
        check(r.rdata, {IMPL, VARI, 4'hF, PART, REV});
        acc(1'b1, `ADDR_CPU_ID, SZ_WORD, 32'h0);
        acc(1'b0, `ADDR_CPU_ID, SZ_WORD, 32'h0);
        check({28'h0, r.rdata[19:16]}, 32'hF);
    endtask

    // each control bit alone reaches its own output, reserved bits stay clear
    task automatic t_aux;
        int b;
        int pos [5] = '{0, 1, 2, 8, 9};
        for (b = 0; b < 5; b++)
        begin
            acc(1'b1, `ADDR_AUX_CTRL, SZ_WORD, 32'h1 << pos[b]);
            repeat (3) @(posedge ref_clk);
            #1;
            check({27'h0, aux}, 32'h1 << b);
        end
        acc(1'b1, `ADDR_AUX_CTRL, SZ_WORD, 32'hFFFFFFFF);
        acc(1'b0, `ADDR_AUX_CTRL, SZ_WORD, 32'h0);
        check(r.rdata, 32'h00000307);
    endtask

    // narrow accesses where allowed, refusals elsewhere with no state change
    task automatic t_sizes;
        int i;
        logic [31:0] adr [5] = '{`ADDR_SHPR1 + 32'h1, `ADDR_SHPR1 + 32'h2, `ADDR_SHPR1,
            `ADDR_CCR, 32'hE000ED30};
        acc_size_t sz [5] = '{SZ_HALF, SZ_WORD, SZ_BAD, SZ_BYTE, SZ_WORD};
        acc(1'b1, `ADDR_SHPR2 + 32'h1, SZ_BYTE, 32'hA0A0A0A0);
        check({31'h0, r.error}, 32'h0);
        acc(1'b1, `ADDR_SHPR2 + 32'h2, SZ_HALF, 32'h50505050);
        acc(1'b0, `ADDR_SHPR2, SZ_WORD, 32'h0);
        check(r.rdata, 32'h5050A000);
        acc(1'b1, `ADDR_SHPR3 + 32'h3, SZ_BYTE, 32'h70707070);
        acc(1'b0, `ADDR_SHPR3 + 32'h2, SZ_HALF, 32'h0);
        check(r.rdata, 32'h70000000);
        acc(1'b1, `ADDR_SHPR1, SZ_WORD, 32'h10203040);
        for (i = 0; i < 5; i++)
        begin
            acc(1'b1, adr[i], sz[i], 32'hFFFFFFFF);
            check({31'h0, r.error}, 32'h1);
        end
        acc(1'b0, `ADDR_SHPR1, SZ_WORD, 32'h0);
        check(r.rdata, 32'h10203040);
        acc(1'b0, `ADDR_CCR, SZ_WORD, 32'h0);
        check(r.rdata, 32'h00000200);
    endtask

    // capture both faults, read address before flag, clear memory flag by byte write and bus flag by word write
    task automatic t_fault;
        @(posedge ref_clk);
        mf_cap <= 1'b1;
        mf_addr <= 32'h20001234;
        bf_cap <= 1'b1;
        bf_addr <= 32'h40000ABC;
        @(posedge ref_clk);
        mf_cap <= 1'b0;
        bf_cap <= 1'b0;
        mf_addr <= 32'hDFFFEDCB;
        bf_addr <= 32'hBFFFF543;
        acc(1'b0, `ADDR_MMFAR, SZ_WORD, 32'h0);
        check(r.rdata, 32'h20001234);
        acc(1'b0, `ADDR_BFAR, SZ_WORD, 32'h0);
        check(r.rdata, 32'h40000ABC);
        acc(1'b0, `ADDR_CFSR + 32'h1, SZ_BYTE, 32'h0);
        check(r.rdata, 32'h00008080);
        acc(1'b1, `ADDR_CFSR, SZ_BYTE, 32'h80808080);
        acc(1'b1, `ADDR_CFSR + 32'h2, SZ_HALF, 32'hFFFFFFFF);
        acc(1'b0, `ADDR_CFSR, SZ_WORD, 32'h0);
        check(r.rdata, 32'h00008000);
        acc(1'b1, `ADDR_CFSR, SZ_WORD, 32'h00008000);
        acc(1'b0, `ADDR_CFSR, SZ_WORD, 32'h0);
        check(r.rdata, 32'h0);
    endtask

    // edge numbers of the trigger range and one beyond it
    task automatic t_trig;
        int i;
        int v [3] = '{0, 239, 240};
        for (i = 0; i < 3; i++)
        begin
            acc(1'b1, `ADDR_TRIGGER, SZ_WORD, 32'(v[i]));
            check({31'h0, trig_v}, {31'h0, v[i] < 240});
            check({23'h0, trig_n}, 32'(v[i]));
        end
        acc(1'b0, `ADDR_TRIGGER, SZ_WORD, 32'h0);
        check(r.rdata, 32'h0);
    endtask

    task automatic print_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        errors = 0;
        tests_run = 0;
        rst_b = 1'b0;
        mf_cap = 1'b0;
        bf_cap = 1'b0;
        mf_addr = 32'h0;
        bf_addr = 32'h0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_reset;
        t_aux;
        t_sizes;
        t_fault;
        t_trig;
        print_verdict;
    end

    // whole run needs well under two thousand cycles
    initial
    begin
        #100000;
        errors++;
        print_verdict;
    end
endmodule
